//--- bench/image_sensor_window_timing_ctrl_tb_top.sv
`timescale 1ns/1ps
module image_sensor_window_timing_ctrl_tb_top;
	logic       clk_sys_in = 1'b0;
	logic       reset_n_in = 1'b0;
	logic       enable_in  = 1'b0;
	logic       scl, host_low, sda_oe, sda_o, hs, vs, ex, pd, conv;
	logic [8:0] row, col, r0, c0, c1;
	logic [2:0] lanes;
	logic [5:0] lvl;
	logic [7:0] rd;
	wire        sda_line = ~(host_low | (sda_oe & ~sda_o));
	int         errors = 0;
	int         checks = 0;
	sensor_host_model host_u (.clk_in(clk_sys_in), .sda_in(sda_line), .scl_out(scl), .sda_low_out(host_low));
	sensor_window_timing dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .enable_in(enable_in),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe), .hsync_out(hs),
		.vsync_out(vs), .row_addr_out(row), .col_addr_out(col), .exposing_out(ex),
		.digital_pd_out(pd), .converter_on_out(conv), .adc_lanes_out(lanes), .ref_level_out(lvl));
	initial begin
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic pick(input int s);
		return (s == 0) ? hs : ((s == 1) ? vs : ex);
	endfunction
	// length of the next run of level v, capturing addresses; skip drops a run already under way
	task automatic run_len(input int s, input logic v, input logic skip, output int len);
		int w;
		len = 0;
		for (w = 0; w < 20000 && skip && pick(s) === v; w++) @(negedge clk_sys_in);
		for (w = 0; w < 20000 && pick(s) !== v; w++) @(negedge clk_sys_in);
		while (pick(s) === v && len < 20000) begin
			if (len == 0) r0 = row;
			if (len == 0) c0 = col;
			c1 = col;
			len++;
			@(negedge clk_sys_in);
		end
	endtask
	task automatic test_reset();
		for (int i = 0; i < sensor_pkg::NUM_REGS; i++) begin
			host_u.read_reg(sensor_pkg::REG_ADDR[i], rd);
			chk(24'(rd), 24'(sensor_pkg::REG_RESET[i]));
		end
		host_u.read_reg(8'h40, rd);
		chk(24'(rd), 24'h0);
		chk(24'({pd, conv, lanes}), 24'h17);
		$display("test reset done");
	endtask
	task automatic test_power();
		host_u.write_regs(8'h02, {8'h0c});
		chk(24'(conv), 24'h1);
		host_u.write_regs(8'h02, {8'h0a});
		chk(24'({conv, lanes}), 24'h2);
		// raise level as if low reference count were large
		host_u.write_regs(8'h30, {8'h3a});
		chk(24'(lvl), 24'h3a);
		$display("test power done");
	endtask
	task automatic test_frame();
		int n;
		// window in range, two larger than wanted
		host_u.write_regs(8'h10, {8'h00, 8'h07, 8'h00, 8'h08, 8'h00, 8'h03, 8'h00, 8'h04});
		host_u.write_regs(8'h20, {8'h00, 8'h01, 8'h00, 8'h05});
		host_u.write_regs(8'h25, {8'hff, 8'h00, 8'h01});
		host_u.write_regs(8'h02, {8'h00});
		enable_in = 1'b1;
		run_len(2, 1'b1, 1'b1, n);
		chk(24'(n), 24'h1ab);
		run_len(1, 1'b1, 1'b0, n);
		chk(24'(n), 24'h5);
		for (int r = 0; r < 3; r++) begin
			if (r > 0) run_len(0, 1'b0, 1'b0, n);
			if (r > 0) chk(24'(n), 24'hd);
			run_len(0, 1'b1, 1'b0, n);
			chk(24'({n[5:0], r0, c0}), {6'h04, 9'(7 + r), 9'h008});
			chk(24'(c1), 24'hb);
		end
		$display("test frame done");
	endtask
	task automatic test_divider();
		int n;
		host_u.write_regs(8'h25, {8'h00, 8'h00, 8'h0a});
		host_u.write_regs(8'h01, {8'h05});
		run_len(2, 1'b1, 1'b1, n);
		run_len(2, 1'b1, 1'b1, n);
		chk(24'(n), 24'ha);
		host_u.write_regs(8'h28, {8'h02});
		run_len(1, 1'b1, 1'b1, n);
		chk(24'(n), 24'h14);
		host_u.write_regs(8'h28, {8'h0c});
		run_len(1, 1'b1, 1'b1, n);
		chk(24'(n), 24'h5);
		$display("test divider done");
	endtask
	task automatic test_sleep();
		host_u.write_regs(8'h02, {8'h08});
		repeat (3) @(negedge clk_sys_in);
		chk(24'({ex, vs, hs, pd}), 24'h0);
		host_u.write_regs(8'h02, {8'h04});
		enable_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		chk(24'({ex, vs, hs, pd, conv}), 24'h3);
		chk(24'(host_u.nacks), 24'h0);
		$display("test sleep done");
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run of about 2 ms
	initial begin
		#9000000;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		test_reset();
		test_power();
		test_frame();
		test_divider();
		test_sleep();
		report_and_stop();
	end
endmodule

//--- bench/sensor_host_model.sv
`timescale 1ns/1ps
// serial-bus host that programs the sensor for the capture side
module sensor_host_model (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	int nacks = 0;
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// quarter bit; lines change only after a falling clock edge
	task automatic qtr();
		repeat (4) @(negedge clk_in);
	endtask
	// data set while scl low, wire sampled at end of the high phase
	task automatic bit_io(input logic tx, output logic rx);
		qtr();
		sda_low_out = ~tx;
		qtr();
		scl_out = 1'b1;
		qtr();
		qtr();
		rx = sda_in;
		scl_out = 1'b0;
	endtask
	// mode 0 host sends and expects an ack, 1 host acks, 2 host nacks
	task automatic byte_io(input logic [7:0] tx, input logic [1:0] mode, output logic [7:0] rx);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(mode != 2'h1, a);
		if (mode == 2'h0 && a !== 1'b0) nacks++;
	endtask
	task automatic start();
		qtr();
		sda_low_out = 1'b0;
		qtr();
		scl_out = 1'b1;
		qtr();
		sda_low_out = 1'b1;
		qtr();
		scl_out = 1'b0;
	endtask
	task automatic stop();
		qtr();
		sda_low_out = 1'b1;
		qtr();
		scl_out = 1'b1;
		qtr();
		sda_low_out = 1'b0;
		qtr();
	endtask
	// burst write; the device pointer steps after every data byte
	task automatic write_regs(input logic [7:0] regn, input logic [7:0] d[$]);
		logic [7:0] x;
		start();
		byte_io({sensor_pkg::SLAVE_ADDR, 1'b0}, 2'h0, x);
		byte_io(regn, 2'h0, x);
		foreach (d[i]) byte_io(d[i], 2'h0, x);
		stop();
	endtask
	task automatic read_reg(input logic [7:0] regn, output logic [7:0] data);
		logic [7:0] x;
		start();
		byte_io({sensor_pkg::SLAVE_ADDR, 1'b0}, 2'h0, x);
		byte_io(regn, 2'h0, x);
		start();
		byte_io({sensor_pkg::SLAVE_ADDR, 1'b1}, 2'h0, x);
		byte_io(8'hff, 2'h2, data);
		stop();
	endtask
endmodule

//--- hdl/sensor_reg_bank.sv
`timescale 1ns/1ps
module sensor_reg_bank (
	input  wire logic                                     clk_in,
	input  wire logic                                     rst_n_in,
	input  wire logic                                     wr_en_in,
	input  wire logic [7:0]                               wr_addr_in,
	input  wire logic [7:0]                               wr_data_in,
	input  wire logic [7:0]                               rd_addr_in,
	output logic      [7:0]                               rd_data_out,
	output logic      [sensor_pkg::NUM_REGS-1:0][7:0]     bytes_out
);
	// byte storage; unmapped writes are dropped
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// exposure bytes reset to 500 lines
			for (int i = 0; i < sensor_pkg::NUM_REGS; i++) begin
				bytes_out[i] <= sensor_pkg::REG_RESET[i];
			end
		end else if (wr_en_in) begin
			for (int i = 0; i < sensor_pkg::NUM_REGS; i++) begin
				if (wr_addr_in == sensor_pkg::REG_ADDR[i]) begin
					bytes_out[i] <= wr_data_in;
				end
			end
		end
	end

	// registered read; unmapped addresses read zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= 8'h00;
		end else begin
			rd_data_out <= 8'h00;
			for (int i = 0; i < sensor_pkg::NUM_REGS; i++) begin
				if (rd_addr_in == sensor_pkg::REG_ADDR[i]) begin
					rd_data_out <= bytes_out[i];
				end
			end
		end
	end
endmodule

//--- hdl/sensor_window_timing.sv
`timescale 1ns/1ps
// Contract
// - active-high software sleep bit, reset 1, stops the sequencer like the enable pin low but leaves digital power on.
// - while asleep, converter keep-on bit decides whether converters stay powered.
// - digital block powers down whenever the enable pin is low.
// - colour bit 0 uses three converters; 1 uses one converter, green gain only.
// - first row held in a byte pair, reset 6; software keeps it 6..306.
// - first column held in a byte pair, reset 6; software keeps it 6..406.
// - last row equals first row plus window rows minus one; rows reset 0x012e.
// - last column equals first column plus columns minus one; reset 0x0192.
// - hsync low between lines for line blank plus twelve pixel periods.
// - vsync active for frame blank pixel periods; reset 3.
// - line unit uses middle and low exposure bytes; pixel unit uses all three.
// - exposure registers reset to 500 lines.
// - digital clock divided by 2 to the divider code up to 11, code 0 and codes 12..15 undivided.
// - reference level register, reset 0x38, sets the conversion start level.
// - exposure is count pixels, or count times (414 plus hsync low) pixels.
// - exposure unit bit 0 selects lines, 1 selects pixel periods.
module sensor_window_timing (
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	input  wire logic       enable_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic            hsync_out,
	output logic            vsync_out,
	output logic [8:0]      row_addr_out,
	output logic [8:0]      col_addr_out,
	output logic            exposing_out,
	output logic            digital_pd_out,
	output logic            converter_on_out,
	output logic [2:0]      adc_lanes_out,
	output logic [5:0]      ref_level_out
);
	logic                                     rst_meta_ff;
	logic                                     rst_sync_ff;
	logic                                     scl_ff;
	logic                                     sda_ff;
	sensor_pkg::link_state_t                  link_ff;
	logic [3:0]                               bits_ff;
	logic [7:0]                               shift_ff;
	logic [7:0]                               out_ff;
	logic [7:0]                               ptr_ff;
	logic                                     rw_ff;
	logic                                     sda_oe_ff;
	logic                                     wr_en_ff;
	logic [7:0]                               wr_addr_ff;
	logic [7:0]                               wr_data_ff;
	logic [7:0]                               rd_data;
	logic [sensor_pkg::NUM_REGS-1:0][7:0]     regs;
	sensor_pkg::frame_cfg_t                   live_cfg;
	sensor_pkg::frame_cfg_t                   cfg_ff;
	sensor_pkg::frame_state_t                 state_ff;
	logic [10:0]                              div_ff;
	logic                                     tick;
	logic                                     awake;
	logic [16:0]                              cnt_ff;
	logic [23:0]                              units_ff;
	logic [8:0]                               row_ff;
	logic [8:0]                               col_ff;
	logic [16:0]                              hblank_len;
	logic [16:0]                              line_len;
	logic [23:0]                              exp_target;
	logic [8:0]                               last_row;
	logic [8:0]                               last_col;
	logic [8:0]                               col_now;
	logic [8:0]                               row_now;
	logic                                     frame_start;
	logic                                     hsync_ff;
	logic                                     vsync_ff;
	logic [8:0]                               row_addr_ff;
	logic [8:0]                               col_addr_ff;
	logic                                     exposing_ff;
	logic                                     digital_pd_ff;
	logic                                     converter_on_ff;
	logic [2:0]                               adc_lanes_ff;
	logic [5:0]                               ref_level_ff;

	// reset release through two flops
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// serial bus line history for edge and start/stop detection
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
		end else begin
			scl_ff <= scl_in;
			sda_ff <= sda_in;
		end
	end

	// serial bus slave: address, register pointer, auto-incrementing data bytes
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			link_ff    <= sensor_pkg::L_IDLE;
			bits_ff    <= 4'h0;
			shift_ff   <= 8'h00;
			out_ff     <= 8'h00;
			ptr_ff     <= 8'h00;
			rw_ff      <= 1'b0;
			sda_oe_ff  <= 1'b0;
			wr_en_ff   <= 1'b0;
			wr_addr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
		end else begin
			wr_en_ff <= 1'b0;
			if (scl_ff && scl_in && sda_ff && !sda_in) begin
				link_ff   <= sensor_pkg::L_ADDR;
				bits_ff   <= 4'h0;
				sda_oe_ff <= 1'b0;
			end else if (scl_ff && scl_in && !sda_ff && sda_in) begin
				link_ff   <= sensor_pkg::L_IDLE;
				sda_oe_ff <= 1'b0;
			end else if (!scl_ff && scl_in) begin
				case (link_ff)
					sensor_pkg::L_ADDR, sensor_pkg::L_REG, sensor_pkg::L_WRITE: begin
						shift_ff <= {shift_ff[6:0], sda_in};
						bits_ff  <= bits_ff + 4'h1;
					end
					sensor_pkg::L_RACK: begin
						if (sda_in) begin
							link_ff <= sensor_pkg::L_IDLE;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_ff && !scl_in) begin
				case (link_ff)
					sensor_pkg::L_ADDR: begin
						if (bits_ff == 4'h8) begin
							if (shift_ff[7:1] == sensor_pkg::SLAVE_ADDR) begin
								rw_ff     <= shift_ff[0];
								sda_oe_ff <= 1'b1;
								link_ff   <= sensor_pkg::L_AACK;
							end else begin
								link_ff <= sensor_pkg::L_IDLE;
							end
						end
					end
					sensor_pkg::L_AACK, sensor_pkg::L_RACK: begin
						if (rw_ff) begin
							out_ff    <= rd_data;
							sda_oe_ff <= ~rd_data[7];
							bits_ff   <= 4'h1;
							link_ff   <= sensor_pkg::L_READ;
						end else begin
							sda_oe_ff <= 1'b0;
							bits_ff   <= 4'h0;
							link_ff   <= sensor_pkg::L_REG;
						end
					end
					sensor_pkg::L_REG: begin
						if (bits_ff == 4'h8) begin
							ptr_ff    <= shift_ff;
							sda_oe_ff <= 1'b1;
							link_ff   <= sensor_pkg::L_WACK;
						end
					end
					sensor_pkg::L_WRITE: begin
						if (bits_ff == 4'h8) begin
							wr_en_ff   <= 1'b1;
							wr_addr_ff <= ptr_ff;
							wr_data_ff <= shift_ff;
							ptr_ff     <= ptr_ff + 8'h01;
							sda_oe_ff  <= 1'b1;
							link_ff    <= sensor_pkg::L_WACK;
						end
					end
					sensor_pkg::L_WACK: begin
						sda_oe_ff <= 1'b0;
						bits_ff   <= 4'h0;
						link_ff   <= sensor_pkg::L_WRITE;
					end
					sensor_pkg::L_READ: begin
						if (bits_ff == 4'h8) begin
							sda_oe_ff <= 1'b0;
							ptr_ff    <= ptr_ff + 8'h01;
							link_ff   <= sensor_pkg::L_RACK;
						end else begin
							out_ff    <= {out_ff[6:0], 1'b0};
							sda_oe_ff <= ~out_ff[6];
							bits_ff   <= bits_ff + 4'h1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	sensor_reg_bank u_regs (
		.clk_in      (clk_sys_in),
		.rst_n_in    (rst_sync_ff),
		.wr_en_in    (wr_en_ff),
		.wr_addr_in  (wr_addr_ff),
		.wr_data_in  (wr_data_ff),
		.rd_addr_in  (ptr_ff),
		.rd_data_out (rd_data),
		.bytes_out   (regs)
	);

	always_comb begin
		live_cfg.window_first_row    = {regs[sensor_pkg::IX_ROW_H][0], regs[sensor_pkg::IX_ROW_L]};
		live_cfg.window_first_column = {regs[sensor_pkg::IX_COL_H][0], regs[sensor_pkg::IX_COL_L]};
		live_cfg.window_rows         = {regs[sensor_pkg::IX_HGT_H][0], regs[sensor_pkg::IX_HGT_L]};
		live_cfg.window_columns      = {regs[sensor_pkg::IX_WID_H][0], regs[sensor_pkg::IX_WID_L]};
		live_cfg.line_blank          = {regs[sensor_pkg::IX_HBL_H], regs[sensor_pkg::IX_HBL_L]};
		live_cfg.frame_blank         = {regs[sensor_pkg::IX_VBL_H], regs[sensor_pkg::IX_VBL_L]};
		live_cfg.exposure            = {regs[sensor_pkg::IX_EXP_H], regs[sensor_pkg::IX_EXP_M],
			regs[sensor_pkg::IX_EXP_L]};
		live_cfg.pixel_unit          = regs[sensor_pkg::IX_MODE][sensor_pkg::PIXEL_UNIT_BIT];
	end

	// enable pin and soft sleep bit act alike for sequencer and converters; only the pin powers digital down
	assign awake = enable_in && !regs[sensor_pkg::IX_POWER][sensor_pkg::SOFT_SLEEP_N_BIT];

	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			div_ff <= 11'h000;
		end else begin
			div_ff <= tick ? 11'h000 : div_ff + 11'h001;
		end
	end
	assign tick = (div_ff & sensor_pkg::div_mask(regs[sensor_pkg::IX_DIV][3:0])) ==
		sensor_pkg::div_mask(regs[sensor_pkg::IX_DIV][3:0]);

	// hsync low length; line length for exposure
	assign hblank_len = {1'b0, cfg_ff.line_blank} + sensor_pkg::HBLANK_EXTRA;
	assign line_len   = sensor_pkg::LINE_BASE_PIXELS + hblank_len;
	// unit selects which exposure bytes count
	assign exp_target = cfg_ff.pixel_unit ? cfg_ff.exposure : {8'h00, cfg_ff.exposure[15:0]};
	assign last_row   = 9'(cfg_ff.window_first_row + cfg_ff.window_rows - 9'h001);
	assign last_col   = 9'(cfg_ff.window_first_column + cfg_ff.window_columns - 9'h001);
	// pixel being read now; the address outputs show it one clock later
	assign col_now     = 9'(cfg_ff.window_first_column + col_ff);
	assign row_now     = 9'(cfg_ff.window_first_row + row_ff);
	assign frame_start = tick && ((state_ff == sensor_pkg::ST_SLEEP && awake) ||
		(state_ff == sensor_pkg::ST_ACTIVE && col_now == last_col && row_now == last_row));

	// settings taken together at frame start
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			cfg_ff <= '0;
		end else if (frame_start) begin
			cfg_ff <= live_cfg;
		end
	end

	// frame sequencer: exposure, vsync, then lines of blank and active pixels
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= sensor_pkg::ST_SLEEP;
			cnt_ff   <= 17'h00000;
			units_ff <= 24'h000000;
			row_ff   <= 9'h000;
			col_ff   <= 9'h000;
		end else if (!awake) begin
			state_ff <= sensor_pkg::ST_SLEEP;
		end else if (frame_start) begin
			state_ff <= sensor_pkg::ST_EXPOSE;
			cnt_ff   <= 17'h00000;
			units_ff <= 24'h000000;
		end else if (tick) begin
			case (state_ff)
				sensor_pkg::ST_EXPOSE: begin
					// count pixel periods or whole lines
					if (units_ff >= exp_target || (units_ff + 24'h000001 == exp_target &&
						(cfg_ff.pixel_unit || cnt_ff == line_len - 17'h00001))) begin
						state_ff <= sensor_pkg::ST_VSYNC;
						cnt_ff   <= 17'h00001;
					end else if (cfg_ff.pixel_unit || cnt_ff == line_len - 17'h00001) begin
						units_ff <= units_ff + 24'h000001;
						cnt_ff   <= 17'h00000;
					end else begin
						cnt_ff <= cnt_ff + 17'h00001;
					end
				end
				sensor_pkg::ST_VSYNC: begin
					if (cnt_ff >= {1'b0, cfg_ff.frame_blank}) begin
						state_ff <= sensor_pkg::ST_HBLANK;
						cnt_ff   <= 17'h00001;
						row_ff   <= 9'h000;
					end else begin
						cnt_ff <= cnt_ff + 17'h00001;
					end
				end
				sensor_pkg::ST_HBLANK: begin
					if (cnt_ff == hblank_len) begin
						state_ff <= sensor_pkg::ST_ACTIVE;
						col_ff   <= 9'h000;
					end else begin
						cnt_ff <= cnt_ff + 17'h00001;
					end
				end
				sensor_pkg::ST_ACTIVE: begin
					if (col_now == last_col) begin
						state_ff <= sensor_pkg::ST_HBLANK;
						cnt_ff   <= 17'h00001;
						row_ff   <= row_ff + 9'h001;
					end else begin
						col_ff <= col_ff + 9'h001;
					end
				end
				default: begin
					state_ff <= sensor_pkg::ST_SLEEP;
				end
			endcase
		end
	end

	// pixel address outputs
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			row_addr_ff <= 9'h000;
			col_addr_ff <= 9'h000;
		end else begin
			row_addr_ff <= row_now;
			col_addr_ff <= col_now;
		end
	end

	// sync, power and converter outputs
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			hsync_ff        <= 1'b0;
			vsync_ff        <= 1'b0;
			exposing_ff     <= 1'b0;
			digital_pd_ff   <= 1'b1;
			converter_on_ff <= 1'b0;
			adc_lanes_ff    <= 3'h0;
			ref_level_ff    <= 6'h00;
		end else begin
			hsync_ff      <= state_ff == sensor_pkg::ST_ACTIVE;
			vsync_ff      <= state_ff == sensor_pkg::ST_VSYNC;
			exposing_ff   <= state_ff == sensor_pkg::ST_EXPOSE;
			// pin low forces digital power down
			digital_pd_ff <= !enable_in;
			// converters kept on while asleep only if asked
			converter_on_ff <= awake || regs[sensor_pkg::IX_POWER][sensor_pkg::KEEP_ON_BIT];
			// three lanes for colour, one for mono
			adc_lanes_ff  <= regs[sensor_pkg::IX_POWER][sensor_pkg::MONO_BIT] ?
				sensor_pkg::LANES_MONO : sensor_pkg::LANES_COLOR;
			ref_level_ff  <= regs[sensor_pkg::IX_REF][5:0];
		end
	end

	assign sda_out          = 1'b0;
	assign sda_oe_out       = sda_oe_ff;
	assign hsync_out        = hsync_ff;
	assign vsync_out        = vsync_ff;
	assign row_addr_out     = row_addr_ff;
	assign col_addr_out     = col_addr_ff;
	assign exposing_out     = exposing_ff;
	assign digital_pd_out   = digital_pd_ff;
	assign converter_on_out = converter_on_ff;
	assign adc_lanes_out    = adc_lanes_ff;
	assign ref_level_out    = ref_level_ff;

	chk_sleep_pin_bit: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		!awake |=> state_ff == sensor_pkg::ST_SLEEP) else $error("sleep not entered");
	chk_converter_power: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(!awake && !regs[sensor_pkg::IX_POWER][sensor_pkg::KEEP_ON_BIT]) |=> !converter_on_out)
		else $error("converter left on");
	chk_digital_pd: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		!enable_in |=> digital_pd_out ##1 !hsync_out) else $error("digital not down");
	chk_mono_lanes: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		regs[sensor_pkg::IX_POWER][sensor_pkg::MONO_BIT] |=> adc_lanes_out == 3'h2)
		else $error("mono lanes wrong");
	chk_hblank_len: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(awake && tick && state_ff == sensor_pkg::ST_HBLANK && cnt_ff != hblank_len) |=>
		state_ff == sensor_pkg::ST_HBLANK || !awake) else $error("hsync low too short");
	chk_vsync_source: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		$rose(vsync_out) |-> $past(state_ff) == sensor_pkg::ST_VSYNC) else $error("vsync misplaced");
	chk_row_end: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(awake && tick && state_ff == sensor_pkg::ST_ACTIVE && col_now == last_col
		&& row_now == last_row) |=> state_ff == sensor_pkg::ST_EXPOSE) else $error("frame end missed");
	chk_cfg_stable: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		!frame_start |=> $stable(cfg_ff)) else $error("settings changed mid frame");
	chk_undivided: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		regs[sensor_pkg::IX_DIV][3:0] == 4'h0 && $past(regs[sensor_pkg::IX_DIV][3:0]) == 4'h0 |-> tick)
		else $error("code zero divided");
endmodule

//--- include/sensor_pkg.sv
package sensor_pkg;
	// register map: index, serial-bus address and reset value
	localparam int NUM_REGS = 19;
	localparam int IX_MODE  = 0;
	localparam int IX_POWER = 1;
	localparam int IX_ROW_H = 2;
	localparam int IX_ROW_L = 3;
	localparam int IX_COL_H = 4;
	localparam int IX_COL_L = 5;
	localparam int IX_HGT_H = 6;
	localparam int IX_HGT_L = 7;
	localparam int IX_WID_H = 8;
	localparam int IX_WID_L = 9;
	localparam int IX_HBL_H = 10;
	localparam int IX_HBL_L = 11;
	localparam int IX_VBL_H = 12;
	localparam int IX_VBL_L = 13;
	localparam int IX_EXP_H = 14;
	localparam int IX_EXP_M = 15;
	localparam int IX_EXP_L = 16;
	localparam int IX_DIV   = 17;
	localparam int IX_REF   = 18;
	localparam logic [7:0] REG_ADDR [NUM_REGS] = '{8'h01, 8'h02, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
		8'h16, 8'h17, 8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h28, 8'h30};
	localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h04, 8'h08, 8'h00, 8'h06, 8'h00, 8'h06, 8'h01, 8'h2e,
		8'h01, 8'h92, 8'h00, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01, 8'hf4, 8'h00, 8'h38};
	// field positions
	localparam int SOFT_SLEEP_N_BIT = 3;
	localparam int KEEP_ON_BIT      = 2;
	localparam int MONO_BIT         = 1;
	localparam int PIXEL_UNIT_BIT   = 0;
	// timing constants in pixel periods, then divider code limit and converter lane masks
	localparam logic [16:0] LINE_BASE_PIXELS = 17'h0019e;
	localparam logic [16:0] HBLANK_EXTRA     = 17'h0000c;
	localparam logic [3:0]  DIV_MAX_CODE     = 4'hb;
	localparam logic [2:0]  LANES_COLOR      = 3'h7;
	localparam logic [2:0]  LANES_MONO       = 3'h2;
	// serial-bus slave address, arbitrary value
	localparam logic [6:0]  SLAVE_ADDR       = 7'h2a;

	typedef struct packed {
		logic [8:0]  window_first_row;
		logic [8:0]  window_first_column;
		logic [8:0]  window_rows;
		logic [8:0]  window_columns;
		logic [15:0] line_blank;
		logic [15:0] frame_blank;
		logic [23:0] exposure;
		logic        pixel_unit;
	} frame_cfg_t;

	typedef enum logic [2:0] {ST_SLEEP, ST_EXPOSE, ST_VSYNC, ST_HBLANK, ST_ACTIVE} frame_state_t;
	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_AACK, L_REG, L_WRITE, L_WACK, L_READ, L_RACK} link_state_t;

	// mask of low counter bits for a divider code; reserved codes give no division
	function automatic logic [10:0] div_mask(input logic [3:0] code);
		logic [11:0] m;
		m = 12'h000;
		if (code <= DIV_MAX_CODE) begin
			m = (12'h001 << code) - 12'h001;
		end
		return m[10:0];
	endfunction
endpackage
